/* File: hdl/crt_pkg.sv */
// Package for the coordinated run/trigger bus node.
// Assumes one 125 MHz clock domain; all timing counts live here.
package crt_pkg;
  localparam int unsigned CRT_CLK_MHZ = 125;
  // Start pulse width on the bus, in ns, and its cycle count
  localparam int unsigned CRT_START_PULSE_NS = 40;
  localparam int unsigned CRT_START_PULSE_CYC =
    (CRT_START_PULSE_NS * CRT_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] CRT_START_PULSE_CNT = 4'(CRT_START_PULSE_CYC);
  // Program counter width and its reset value
  localparam int unsigned CRT_ADDR_W = 32;
  localparam logic [31:0] CRT_PC_RESET = 32'h0000_0000;
  // Start sequence phases for trace start
  localparam logic [1:0] CRT_SEQ_DISABLE = 2'h0;
  localparam logic [1:0] CRT_SEQ_RECV = 2'h1;
  localparam logic [1:0] CRT_SEQ_DRIVE = 2'h2;
  localparam logic [1:0] CRT_SEQ_DONE = 2'h3;
  typedef enum logic [1:0] {
    CRT_RUN_MONITOR,
    CRT_RUN_WAIT,
    CRT_RUN_USER
  } crt_run_t;
endpackage

/* File: hdl/crt_pin_sync.sv */
// Three-flop pin synchroniser with agreement filter.
// Assumes an asynchronous pin input and the node clock.
`timescale 1ns/10ps
`default_nettype none
module crt_pin_sync (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Pin and filtered level
  input wire logic pin_i,
  input wire logic idle_level_i,
  output logic level_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;

  // Stages hold the pin relative to its idle level, so reset lands on idle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_i ^ idle_level_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Level follows once second and third stages agree
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      level_reg <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      level_reg <= s3_reg;
    end
  end

  assign level_o = level_reg ^ idle_level_i;
endmodule
`default_nettype wire

/* File: hdl/crt_node.sv */
// One node's logic on the three-line run/trigger coordination bus.
// Assumes bus pins are open-drain wired with identical nodes; the wire
// level is resolved outside from the output enables.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// [RULE1] Without participation enable, ignore and never drive run, break, start activity.
// [RULE2] Run command with bus not ready holds node waiting and reports it.
// [RULE3] Waiting nodes all start user code when ready line goes true.
// [RULE4] One participant breaking to monitor sends all others waiting until ready.
// [RULE5] Enabling while running with bus not ready breaks node, then waits. Here the node stays in monitor until a run command.
// [RULE6] Waiting node runs once last stopped participant runs and releases ready.
// [RULE7] Enabling while running with bus ready leaves node running.
// [RULE8] Break on a non-participating node leaves participants running.
// [RULE9] Re-enabling a node stopped in monitor drops ready, participants go waiting.
// [RULE10] Any node may emit start pulse; participants break then resume on ready. Here a node emits only with participation enabled.
// [RULE11] Preset run address loads program counter on start pulse; else unchanged.
// [RULE12] Reset of a participating node breaks the others into waiting.
// [RULE13] Analyzer trigger drives internal line, forwarded to bus trigger when routed.
// [RULE14] Bus trigger can drive internal line used as analyzer arm and trigger.
// [RULE15] Trigger output sticks after trace; cleared by halt+start, break service, status.
// [RULE16] Starting receiver with stale sender trigger false-triggers; use start-armed traces.
// [RULE17] Start-armed trace stays unstarted until the bus start pulse arrives.
// [RULE18] On start pulse: drivers off, receivers start, then drivers start.
// [RULE19] Ready is wired-AND; stopped participants in monitor hold it low.
module crt_node
  import crt_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Participation and run control
  input wire logic part_en_i,
  input wire logic run_cmd_i,
  input wire logic break_cmd_i,
  input wire logic emit_start_i,
  output logic waiting_o,
  output logic in_monitor_o,
  output logic running_o,
  // Start-pulse run address
  input wire logic preset_en_i,
  input wire logic [CRT_ADDR_W-1:0] preset_addr_i,
  input wire logic pc_load_i,
  input wire logic [CRT_ADDR_W-1:0] pc_value_i,
  output logic [CRT_ADDR_W-1:0] pc_o,
  // Trigger routing
  input wire logic tgout_en_i,
  input wire logic bus_rx_route_i,
  input wire logic bus_drive_route_i,
  input wire logic analyzer_trig_i,
  input wire logic trace_start_i,
  input wire logic trace_halt_i,
  input wire logic trace_start_armed_i,
  input wire logic status_req_i,
  input wire logic break_on_trig_i,
  output logic internal_trigger_a_o,
  output logic analyzer_arm_o,
  output logic trace_go_o,
  output logic trig_out_o,
  // Bus pins, open drain; ready driven low, start and trigger driven high
  input wire logic bus_ready_i,
  output logic bus_ready_o,
  output logic bus_ready_oe_o,
  input wire logic bus_start_i,
  output logic bus_start_o,
  output logic bus_start_oe_o,
  input wire logic bus_trig_i,
  output logic bus_trig_o,
  output logic bus_trig_oe_o
);
  crt_run_t run_reg;
  crt_run_t run_next;
  logic ready_lvl;
  logic start_lvl;
  logic trig_lvl;
  logic start_lvl_d_reg;
  logic start_rx;
  logic ready_d_reg;
  logic ready_fall;
  logic part_en_d_reg;
  logic part_rise;
  logic rst_hold_reg;
  logic [3:0] start_cnt_reg;
  logic [CRT_ADDR_W-1:0] pc_reg;
  logic trig_out_reg;
  logic trig_break_reg;
  logic armed_reg;
  logic [1:0] seq_reg;
  logic trace_go_reg;
  logic bus_trig_mask_reg;
  logic user_break;

  // Monitor decode, shared by ready drive, status and trigger clears
  function automatic logic is_mon(input crt_run_t s);
    return s == CRT_RUN_MONITOR;
  endfunction

  // Bus inputs synchronised; ready idles high, start and trigger active high
  crt_pin_sync u_sync_ready (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .pin_i(bus_ready_i),
    .idle_level_i(1'b1),
    .level_o(ready_lvl)
  );
  crt_pin_sync u_sync_start (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .pin_i(bus_start_i),
    .idle_level_i(1'b0),
    .level_o(start_lvl)
  );
  crt_pin_sync u_sync_trig (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .pin_i(bus_trig_i),
    .idle_level_i(1'b0),
    .level_o(trig_lvl)
  );

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      start_lvl_d_reg <= 1'b0;
      // Ready idles high, so no false fall follows reset
      ready_d_reg <= 1'b1;
      part_en_d_reg <= 1'b0;
    end else begin
      start_lvl_d_reg <= start_lvl;
      ready_d_reg <= ready_lvl;
      part_en_d_reg <= part_en_i;
    end
  end

  assign start_rx = part_en_i && start_lvl && !start_lvl_d_reg; // [RULE1] [RULE10]
  assign ready_fall = !ready_lvl && ready_d_reg;
  assign part_rise = part_en_i && !part_en_d_reg;
  assign user_break = break_cmd_i || (break_on_trig_i && trig_break_reg);

  // Run state
  always_comb begin
    run_next = run_reg;
    unique case (run_reg)
      CRT_RUN_MONITOR: begin
        if (run_cmd_i) begin
          run_next = (part_en_i && !ready_lvl) ? CRT_RUN_WAIT : CRT_RUN_USER; // [RULE2]
        end
      end
      CRT_RUN_WAIT: begin
        if (!part_en_i) begin
          run_next = CRT_RUN_MONITOR;
        end else if (user_break) begin
          run_next = CRT_RUN_MONITOR;
        end else if (ready_lvl) begin
          run_next = CRT_RUN_USER; // [RULE3] [RULE6]
        end
      end
      CRT_RUN_USER: begin
        if (user_break) begin
          run_next = CRT_RUN_MONITOR; // [RULE8]
        end else if (part_rise && !ready_lvl) begin
          run_next = CRT_RUN_MONITOR; // [RULE5]
        end else if (part_en_i && part_en_d_reg && (ready_fall || start_rx)) begin
          run_next = CRT_RUN_WAIT; // [RULE4] [RULE10] [RULE12]
        end
      end
    endcase
    // [RULE7] enabling with ready high falls through and keeps running
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      run_reg <= CRT_RUN_MONITOR;
    end else begin
      run_reg <= run_next;
    end
  end

  // Ready held low one cycle after reset so peers see the reset
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_hold_reg <= 1'b1;
    end else begin
      rst_hold_reg <= 1'b0;
    end
  end

  // Start pulse emitter
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      start_cnt_reg <= 4'h0;
    end else if (emit_start_i && part_en_i && start_cnt_reg == 4'h0) begin
      start_cnt_reg <= CRT_START_PULSE_CNT; // [RULE10]
    end else if (start_cnt_reg != 4'h0) begin
      start_cnt_reg <= start_cnt_reg - 4'h1;
    end
  end

  // Program counter
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_reg <= CRT_PC_RESET;
    end else if (start_rx && preset_en_i) begin
      pc_reg <= preset_addr_i; // [RULE11]
    end else if (pc_load_i) begin
      pc_reg <= pc_value_i;
    end
  end

  // Sticky analyzer trigger output
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_out_reg <= 1'b0;
      trig_break_reg <= 1'b0;
    end else begin
      if (tgout_en_i && analyzer_trig_i) begin
        trig_out_reg <= 1'b1; // [RULE15]
      end else if (trace_go_reg && trace_halt_i) begin
        trig_out_reg <= 1'b0; // [RULE15]
      end else if (is_mon(run_reg) && trig_break_reg) begin
        trig_out_reg <= 1'b0; // [RULE15]
      end else if (status_req_i && is_mon(run_reg)) begin
        trig_out_reg <= 1'b0; // [RULE15]
      end
      if (break_on_trig_i && tgout_en_i && analyzer_trig_i) begin
        trig_break_reg <= 1'b1;
      end else if (run_reg == CRT_RUN_MONITOR) begin
        trig_break_reg <= 1'b0;
      end
    end
  end

  // Trace start, possibly armed on the start pulse
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_reg <= 1'b0;
      seq_reg <= CRT_SEQ_DONE;
      trace_go_reg <= 1'b0;
      bus_trig_mask_reg <= 1'b0;
    end else begin
      if (trace_halt_i) begin
        trace_go_reg <= 1'b0;
      end
      if (trace_start_i && !trace_start_armed_i) begin
        trace_go_reg <= 1'b1;
      end
      if (trace_start_armed_i) begin
        armed_reg <= 1'b1; // [RULE17]
      end
      if (start_rx && armed_reg) begin
        armed_reg <= 1'b0;
        seq_reg <= CRT_SEQ_DISABLE;
        bus_trig_mask_reg <= 1'b1; // [RULE18]
      end else begin
        unique case (seq_reg)
          CRT_SEQ_DISABLE: begin
            seq_reg <= CRT_SEQ_RECV;
            if (bus_drive_route_i) begin
              trace_go_reg <= 1'b1; // [RULE18]
            end
          end
          CRT_SEQ_RECV: begin
            seq_reg <= CRT_SEQ_DRIVE;
          end
          CRT_SEQ_DRIVE: begin
            seq_reg <= CRT_SEQ_DONE;
            bus_trig_mask_reg <= 1'b0;
            if (!bus_drive_route_i) begin
              trace_go_reg <= 1'b1; // [RULE18]
            end
          end
          CRT_SEQ_DONE: begin
            seq_reg <= CRT_SEQ_DONE;
          end
        endcase
      end
    end
  end

  // Outputs
  assign internal_trigger_a_o = (tgout_en_i && trig_out_reg) ||
    (bus_drive_route_i && trig_lvl); // [RULE13] [RULE14]
  assign analyzer_arm_o = bus_drive_route_i && trig_lvl; // [RULE14]
  assign trace_go_o = trace_go_reg;
  assign trig_out_o = trig_out_reg;
  assign running_o = (run_reg == CRT_RUN_USER);
  assign waiting_o = (run_reg == CRT_RUN_WAIT); // [RULE2]
  assign in_monitor_o = is_mon(run_reg);
  assign pc_o = pc_reg;

  // Ready pulled low by participants in monitor, or by a participating node just out of reset.
  // Waiting nodes release it: if they held it, all waiters would deadlock.
  assign bus_ready_o = 1'b0;
  assign bus_ready_oe_o = part_en_i && (rst_hold_reg || is_mon(run_reg)); // [RULE19] [RULE9] [RULE12]
  assign bus_start_o = 1'b1;
  assign bus_start_oe_o = (start_cnt_reg != 4'h0); // [RULE10]
  assign bus_trig_o = 1'b1;
  assign bus_trig_oe_o = bus_rx_route_i && trig_out_reg && tgout_en_i &&
    !bus_trig_mask_reg; // [RULE13] [RULE16]
endmodule
`default_nettype wire

/* File: testbench/crt_node_asserts.sv */
// Bound checker for crt_node port behaviour.
// Assumes one clock domain and the asynchronous high reset.
`timescale 1ns/10ps
`default_nettype none
module crt_node_asserts
  import crt_pkg::*;
(
  // Clock, reset and controls
  input wire logic mclk_i, rst_i, part_en_i, emit_start_i, preset_en_i, pc_load_i,
  // Status and bus
  input wire logic waiting_o, in_monitor_o, running_o,
  input wire logic [CRT_ADDR_W-1:0] pc_o,
  input wire logic bus_ready_i, bus_start_i, bus_ready_oe_o, bus_start_oe_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  a_idle_no_ready: assert property (!part_en_i [*2] |-> !bus_ready_oe_o)
    else $error("ready pulled while disabled");
  a_idle_no_start: assert property (!part_en_i [*7] |-> !bus_start_oe_o)
    else $error("start driven while disabled");
  a_mon_holds_ready: assert property (part_en_i [*2] ##0 in_monitor_o [*2] |-> bus_ready_oe_o)
    else $error("monitor node left ready high");
  a_run_frees_ready: assert property (running_o [*2] |-> !bus_ready_oe_o)
    else $error("running node holds ready low");
  a_start_width: assert property ($rose(bus_start_oe_o) |-> bus_start_oe_o [*5] ##1 !bus_start_oe_o)
    else $error("start pulse width wrong");
  a_start_cause: assert property ($rose(bus_start_oe_o) |-> $past(emit_start_i && part_en_i))
    else $error("start pulse without request");
  a_stop_unready: assert property ((part_en_i && !bus_ready_i) [*8] |-> !running_o)
    else $error("runs while bus not ready");
  a_wait_to_run: assert property ((part_en_i && bus_ready_i && !bus_start_i && waiting_o) [*6] |-> !waiting_o)
    else $error("still waiting with ready high");
  a_pc_kept: assert property (!pc_load_i && !preset_en_i |=> $stable(pc_o))
    else $error("pc changed without preset");
endmodule
bind crt_node crt_node_asserts u_chk (.*);
`default_nettype wire

/* File: testbench/crt_peer.sv */
// Behavioural peer node for the shared run bus.
// Assumes the bench resolves the open-drain wires from the enables.
`timescale 1ns/10ps
`default_nettype none
module crt_peer (
  // Clock, reset and commands
  input wire logic mclk_i, rst_i, part_en_i, run_i, brk_i, emit_i, trig_i,
  // Bus wires and drives
  input wire logic bus_ready_i, bus_start_i,
  output logic ready_oe_o, start_oe_o, trig_oe_o, running_o
);
  // State 0 monitor, 1 waiting, 2 running
  logic [1:0] st_reg;
  logic [2:0] cnt_reg;
  logic sd_reg;
  assign ready_oe_o = part_en_i && st_reg == 2'h0;
  assign start_oe_o = cnt_reg != 3'h0;
  assign trig_oe_o = trig_i;
  assign running_o = st_reg == 2'h2;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= 2'h0;
      cnt_reg <= 3'h0;
      sd_reg <= 1'b0;
    end else begin
      sd_reg <= bus_start_i;
      if (emit_i && part_en_i) cnt_reg <= 3'h5;
      else if (cnt_reg != 3'h0) cnt_reg <= cnt_reg - 3'h1;
      if (brk_i) st_reg <= 2'h0;
      else if (run_i && st_reg == 2'h0) st_reg <= 2'h1;
      else if (part_en_i && bus_start_i && !sd_reg) st_reg <= 2'h1;
      else if (part_en_i && running_o && !bus_ready_i) st_reg <= 2'h1;
      else if (st_reg == 2'h1 && bus_ready_i) st_reg <= 2'h2;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/crt_node_tb.sv */
// Bench: crt_node beside one behavioural peer on a shared bus.
// Assumes open-drain wires resolved here from both enables.
`timescale 1ns/10ps
`default_nettype none
module crt_node_tb;
  logic mclk_i = '0, rst_i = '1, part_en_i = '0, preset_en_i = '0, tgout_en_i = '0;
  logic bus_rx_route_i = '0, bus_drive_route_i = '0, analyzer_trig_i = '0;
  logic p_en = '0, p_rst = '1, p_trig = '0, p_run, stopped;
  logic [10:0] pl = '0;
  logic [31:0] preset_addr_i = '0, pc_o, exp_pc;
  logic waiting_o, in_monitor_o, running_o, internal_trigger_a_o, analyzer_arm_o;
  logic trace_go_o, trig_out_o, bus_ready_oe_o, bus_start_oe_o, bus_trig_oe_o;
  logic pr_oe, ps_oe, pt_oe;
  wire logic rdy = !(bus_ready_oe_o || pr_oe);
  wire logic st = bus_start_oe_o || ps_oe;
  wire logic tg = bus_trig_oe_o || pt_oe;
  int n_fail = 0, num_checks = 0;
  integer seed = 32'h55B4;
  crt_node dut (
    .mclk_i, .rst_i, .part_en_i, .run_cmd_i(pl[0]), .break_cmd_i(pl[1]),
    .emit_start_i(pl[2]), .waiting_o, .in_monitor_o, .running_o,
    .preset_en_i, .preset_addr_i, .pc_load_i(pl[7]), .pc_value_i(32'h0), .pc_o,
    .tgout_en_i, .bus_rx_route_i, .bus_drive_route_i, .analyzer_trig_i,
    .trace_start_i(pl[3]), .trace_halt_i(pl[4]), .trace_start_armed_i(pl[5]),
    .status_req_i(pl[6]), .break_on_trig_i(1'b0), .internal_trigger_a_o,
    .analyzer_arm_o, .trace_go_o, .trig_out_o, .bus_ready_i(rdy), .bus_ready_o(),
    .bus_ready_oe_o, .bus_start_i(st), .bus_start_o(), .bus_start_oe_o,
    .bus_trig_i(tg), .bus_trig_o(), .bus_trig_oe_o);
  crt_peer peer (.mclk_i, .rst_i(p_rst), .part_en_i(p_en), .run_i(pl[8]),
    .brk_i(pl[9]), .emit_i(pl[10]), .trig_i(p_trig), .bus_ready_i(rdy),
    .bus_start_i(st), .ready_oe_o(pr_oe), .start_oe_o(ps_oe), .trig_oe_o(pt_oe),
    .running_o(p_run));
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  task finish_test();
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: flag %b not %b", $time, got, exp);
    end
  endtask
  task chkpc(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: pc %h not %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task pulse(input int k);
    pl[k] = '1;
    tick(1);
    pl = '0;
  endtask
  task run_wait();
    for (int i = 0; i < 40 && running_o !== '1; i++) tick(1);
  endtask
  // Start pulse, noting whether the node left user code meanwhile
  task start_seq(input int k);
    stopped = '0;
    pulse(k);
    for (int i = 0; i < 15; i++) begin
      tick(1);
      stopped = stopped | (running_o !== '1);
    end
    run_wait();
  endtask
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
  initial begin
    tick(4);
    rst_i = '0;
    p_rst = '0;
    tick(2);
    p_en = '1;
    pulse(0);
    run_wait();
    chk1(running_o, '1);
    chk1(bus_ready_oe_o, '0);
    pulse(1);
    part_en_i = '1;
    tick(3);
    chk1(bus_ready_oe_o, '1);
    pulse(0);
    tick(2);
    chk1(waiting_o, '1);
    pulse(8);
    run_wait();
    chk1(running_o, '1);
    pulse(9);
    tick(10);
    chk1(waiting_o, '1);
    pulse(8);
    run_wait();
    chk1(running_o, '1);
    preset_addr_i = $random(seed);
    exp_pc = preset_addr_i;
    preset_en_i = '1;
    start_seq(2);
    chk1(stopped, '1);
    chk1(running_o, '1);
    chkpc(pc_o, exp_pc);
    preset_en_i = '0;
    start_seq(10);
    chk1(stopped, '1);
    chkpc(pc_o, exp_pc);
    p_rst = '1;
    tick(10);
    chk1(waiting_o, '1);
    p_rst = '0;
    pulse(8);
    run_wait();
    part_en_i = '0;
    pulse(1);
    tick(10);
    chk1(p_run, '1);
    part_en_i = '1;
    tick(10);
    chk1(p_run, '0);
    pulse(0);
    run_wait();
    tick(4);
    chk1(p_run, '1);
    tgout_en_i = '1;
    bus_rx_route_i = '1;
    pulse(3);
    analyzer_trig_i = '1;
    tick(2);
    analyzer_trig_i = '0;
    tick(2);
    chk1(internal_trigger_a_o, '1);
    chk1(bus_trig_oe_o, '1);
    pulse(6);
    tick(1);
    chk1(trig_out_o, '1);
    pulse(4);
    pulse(3);
    tick(2);
    chk1(trig_out_o, '0);
    tgout_en_i = '0;
    bus_rx_route_i = '0;
    bus_drive_route_i = '1;
    p_trig = '1;
    tick(6);
    chk1(analyzer_arm_o, '1);
    p_trig = '0;
    pulse(4);
    pulse(5);
    tick(4);
    chk1(trace_go_o, '0);
    pulse(2);
    tick(12);
    chk1(trace_go_o, '1);
    run_wait();
    part_en_i = '0;
    tick(2);
    part_en_i = '1;
    tick(10);
    chk1(running_o, '1);
    part_en_i = '0;
    pulse(9);
    tick(8);
    part_en_i = '1;
    tick(3);
    chk1(in_monitor_o, '1);
    pulse(0);
    tick(2);
    chk1(waiting_o, '1);
    finish_test();
  end
endmodule
`default_nettype wire
